// ### common/kdwl_pkg.sv
// Constants and types for the keypad display word link
// Summary of operation
// - Word is 36 bits, nine 4-bit groups
// - Address 12 bits, sign group, data 20 bits
// - Sign group upper bits zero, LSB negative
// - Groups MSB first, bits MSB first
// - Address group MSB set flags operator error
// - Sign decode keeps only the lowest bit
// - Data octal or BCD chosen by address
// - No range checks on data; octal digit MSBs must be zero
// - Outgoing word zero-forced, decimal sent as BCD
// - Error blocks input and output until Clear
// - Sample key requests every 40 ms
// - Clear starts sequence, then watch Readout/Enter
// - Enter: nine group receives, decode, store
// - After entry, refuse all until Clear
// - Readout: three group receives for address
// - Readout: fetch, format, nine group sends
// - Readout repeats every half second
// - Hold stops refresh; Readout resumes same address
// - Clear after Readout or Hold returns clear
// - At least 80 us between group requests
// - Only a 512-location memory window
`default_nettype none

package kdwl_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned SAMPLE_MS   = 40;
	localparam int unsigned SAMPLE_CYC  = SAMPLE_MS * (CLK_HZ / 1000);
	localparam int unsigned REFRESH_MS  = 500;
	localparam int unsigned REFRESH_CYC = REFRESH_MS * (CLK_HZ / 1000);
	localparam int unsigned GAP_US      = 80;
	localparam int unsigned GAP_CYC     = (GAP_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int unsigned TIMER_W     = 23;
	localparam int unsigned GAP_W       = 10;

	// ----------------------------------------
	// Word layout
	// ----------------------------------------
	localparam int unsigned WORD_BITS   = 36;
	localparam int unsigned GROUP_BITS  = 4;
	localparam logic [3:0]  WORD_GROUPS = 4'h9;
	localparam logic [3:0]  ADDR_GROUPS = 4'h3;
	localparam int unsigned ADDR_HI     = 35;
	localparam int unsigned ADDR_LO     = 24;
	localparam int unsigned SIGN_HI     = 23;
	localparam int unsigned SIGN_LO     = 20;
	localparam int unsigned DATA_HI     = 19;
	localparam int unsigned MAG_W       = 20;
	localparam logic [19:0] DEC_MAX     = 20'h1869f;

	// ----------------------------------------
	// Memory window
	// ----------------------------------------
	localparam int unsigned MEM_DEPTH   = 512;
	localparam int unsigned MEM_AW      = 9;
	localparam int unsigned DEC_ADDR_BIT = 8;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic clear;
		logic enter;
		logic readout;
		logic hold;
	} kdwl_keys_t;

	typedef struct packed {
		logic              neg;
		logic [MAG_W-1:0]  mag;
	} kdwl_word_t;

	localparam kdwl_word_t MEM_RST = '{neg: 1'b0, mag: 20'h00000};

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_CLEAR,
		ST_ENTER,
		ST_DONE,
		ST_RO_ADDR,
		ST_RO_FETCH,
		ST_RO_SEND,
		ST_RO_WAIT,
		ST_HOLD,
		ST_ERROR
	} kdwl_state_t;

endpackage

`default_nettype wire

// ### src/kdwl_core.sv
// Keypad display word link controller with its memory window
`default_nettype none

module kdwl_core
	import kdwl_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES  = SAMPLE_CYC,
	parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
) (
	input  wire logic              clk,                    // System clock
	input  wire logic              rst_n,                  // Async reset
	input  wire kdwl_keys_t        keys,                   // Key request lines
	input  wire logic              link_clk,               // Shift clock from far unit
	input  wire logic              link_din,               // Serial data from far unit
	output logic                   link_dout,              // Serial data to far unit
	output logic                   group_receive_request,  // Ask for one group in
	output logic                   group_send_request,     // Ask for one group out
	output logic                   operator_error,         // Error standing
	input  wire logic [MEM_AW-1:0] mem_addr,               // Window address
	input  wire kdwl_word_t        mem_wdata,              // Window write data
	input  wire logic              mem_wr,                 // Write strobe
	input  wire logic              mem_rd,                 // Read strobe
	output kdwl_word_t             mem_rdata               // Read data
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic addr_ok(input logic [11:0] g);
		return ~(g[11] | g[7] | g[3]);
	endfunction

	function automatic logic [MEM_AW-1:0] addr_of(input logic [11:0] g);
		return {g[10:8], g[6:4], g[2:0]};
	endfunction

	function automatic logic [19:0] bcd_to_bin(input logic [19:0] d);
		return 20'(d[19:16]) * 20'd10000 + 20'(d[15:12]) * 20'd1000
			+ 20'(d[11:8]) * 20'd100 + 20'(d[7:4]) * 20'd10 + 20'(d[3:0]);
	endfunction

	function automatic logic [19:0] bin_to_bcd(input logic [19:0] b);
		logic [16:0] v;
		logic [19:0] d;
		v = (b > DEC_MAX) ? DEC_MAX[16:0] : b[16:0];
		d = '0;
		for (int i = 16; i >= 0; i--) begin
			for (int j = 0; j < 5; j++) begin
				if (d[4*j+:4] > 4'h4) begin
					d[4*j+:4] = d[4*j+:4] + 4'h3;
				end
			end
			d = {d[18:0], v[i]};
		end
		return d;
	endfunction

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	logic       lclk_d_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg  <= 6'h00;
			sync2_reg  <= 6'h00;
			lclk_d_reg <= 1'b0;
		end else begin
			sync1_reg  <= {keys, link_clk, link_din};
			sync2_reg  <= sync1_reg;
			lclk_d_reg <= sync2_reg[1];
		end
	end

	kdwl_keys_t keys_s;
	logic       din_s;
	logic       link_rise;

	assign keys_s    = sync2_reg[5:2];
	assign din_s     = sync2_reg[0];
	assign link_rise = sync2_reg[1] & ~lclk_d_reg;

	// ----------------------------------------
	// Key sampling tick
	// ----------------------------------------
	logic [TIMER_W-1:0] samp_cnt_reg;
	logic               tick_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			samp_cnt_reg <= '0;
			tick_reg     <= 1'b0;
		end else if (samp_cnt_reg == TIMER_W'(SAMPLE_CYCLES - 1)) begin
			samp_cnt_reg <= '0;
			tick_reg     <= 1'b1;
		end else begin
			samp_cnt_reg <= samp_cnt_reg + 1'b1;
			tick_reg     <= 1'b0;
		end
	end

	logic ev_clear;
	logic ev_enter;
	logic ev_readout;
	logic ev_hold;

	assign ev_clear   = tick_reg & keys_s.clear;
	assign ev_enter   = tick_reg & keys_s.enter;
	assign ev_readout = tick_reg & keys_s.readout;
	assign ev_hold    = tick_reg & keys_s.hold;

	// ----------------------------------------
	// Group transfer engine
	// ----------------------------------------
	logic [3:0]           sr_reg;
	logic [1:0]           bit_cnt_reg;
	logic                 busy_reg;
	logic [3:0]           left_reg;
	logic                 dir_tx_reg;
	logic [WORD_BITS-1:0] word_reg;
	logic [GAP_W-1:0]     gap_reg;
	logic                 rx_req_reg;
	logic                 tx_req_reg;
	logic                 done_reg;
	logic                 start_rx_reg;
	logic                 start_tx_reg;
	logic [3:0]           start_n_reg;
	logic                 abort_reg;
	logic [WORD_BITS-1:0] tx_word;
	logic                 can_issue;

	assign can_issue = !busy_reg && (left_reg != 4'h0) && (gap_reg == '0);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_reg <= '0;
		end else if (can_issue && !abort_reg && !start_rx_reg && !start_tx_reg) begin
			gap_reg <= GAP_W'(GAP_CYC - 1);
		end else if (gap_reg != '0) begin
			gap_reg <= gap_reg - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_reg      <= 4'h0;
			bit_cnt_reg <= 2'h0;
			busy_reg    <= 1'b0;
			left_reg    <= 4'h0;
			dir_tx_reg  <= 1'b0;
			word_reg    <= '0;
			rx_req_reg  <= 1'b0;
			tx_req_reg  <= 1'b0;
			done_reg    <= 1'b0;
		end else begin
			rx_req_reg <= 1'b0;
			tx_req_reg <= 1'b0;
			done_reg   <= 1'b0;
			if (abort_reg) begin
				left_reg <= 4'h0;
				busy_reg <= 1'b0;
			end else if (start_rx_reg || start_tx_reg) begin
				left_reg   <= start_n_reg;
				dir_tx_reg <= start_tx_reg;
				if (start_tx_reg) begin
					word_reg <= tx_word;
				end
			end else if (can_issue) begin
				busy_reg    <= 1'b1;
				bit_cnt_reg <= 2'h0;
				rx_req_reg  <= ~dir_tx_reg;
				tx_req_reg  <= dir_tx_reg;
				if (dir_tx_reg) begin
					sr_reg   <= word_reg[WORD_BITS-1 -: GROUP_BITS];
					word_reg <= {word_reg[WORD_BITS-GROUP_BITS-1:0], 4'h0};
				end
			end else if (busy_reg && link_rise) begin
				sr_reg      <= {sr_reg[2:0], din_s};
				bit_cnt_reg <= bit_cnt_reg + 1'b1;
				if (bit_cnt_reg == 2'h3) begin
					busy_reg <= 1'b0;
					left_reg <= left_reg - 1'b1;
					done_reg <= (left_reg == 4'h1);
					if (!dir_tx_reg) begin
						word_reg <= {word_reg[WORD_BITS-GROUP_BITS-1:0], sr_reg[2:0], din_s};
					end
				end
			end
		end
	end

	assign link_dout             = sr_reg[3];
	assign group_receive_request = rx_req_reg;
	assign group_send_request    = tx_req_reg;

	// ----------------------------------------
	// Decode of a received word
	// ----------------------------------------
	logic [MEM_AW-1:0] in_addr;
	logic              in_dec;
	logic              in_ok;
	kdwl_word_t        in_val;

	assign in_addr    = addr_of(word_reg[ADDR_HI:ADDR_LO]);
	assign in_dec     = in_addr[DEC_ADDR_BIT];
	// Zero-constrained positions only; all ones from the far unit trips this
	assign in_ok      = addr_ok(word_reg[ADDR_HI:ADDR_LO]) && (word_reg[SIGN_HI:SIGN_LO+1] == 3'h0)
		&& (in_dec || !(word_reg[19] | word_reg[15] | word_reg[11] | word_reg[7] | word_reg[3]));
	assign in_val.neg = word_reg[SIGN_LO];
	// Decimal digits are not range checked
	assign in_val.mag = in_dec ? bcd_to_bin(word_reg[DATA_HI:0])
		: {5'h00, word_reg[18:16], word_reg[14:12], word_reg[10:8], word_reg[6:4], word_reg[2:0]};

	// ----------------------------------------
	// Memory window
	// ----------------------------------------
	kdwl_word_t        mem [MEM_DEPTH];
	logic              store_reg;
	logic [MEM_AW-1:0] ro_addr_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < MEM_DEPTH; i++) begin
				mem[i] <= MEM_RST;
			end
			mem_rdata <= MEM_RST;
		end else begin
			// Host port wins a same-cycle collision
			if (mem_wr) begin
				mem[mem_addr] <= mem_wdata;
			end else if (store_reg) begin
				mem[in_addr] <= in_val;
			end
			if (mem_rd) begin
				mem_rdata <= mem[mem_addr];
			end
		end
	end

	// ----------------------------------------
	// Encode of an outgoing word
	// ----------------------------------------
	kdwl_word_t  out_val;
	logic [19:0] out_data;

	assign out_val  = mem[ro_addr_reg];
	assign out_data = ro_addr_reg[DEC_ADDR_BIT] ? bin_to_bcd(out_val.mag)
		: {1'b0, out_val.mag[14:12], 1'b0, out_val.mag[11:9], 1'b0, out_val.mag[8:6],
			1'b0, out_val.mag[5:3], 1'b0, out_val.mag[2:0]};
	assign tx_word  = {1'b0, ro_addr_reg[8:6], 1'b0, ro_addr_reg[5:3], 1'b0, ro_addr_reg[2:0],
		3'h0, out_val.neg, out_data};

	// ----------------------------------------
	// Refresh timer
	// ----------------------------------------
	kdwl_state_t        state_reg;
	logic [TIMER_W-1:0] ref_cnt_reg;
	logic               ref_due;

	assign ref_due = (ref_cnt_reg == TIMER_W'(REFRESH_CYCLES - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_cnt_reg <= '0;
		end else if (state_reg == ST_RO_FETCH) begin
			ref_cnt_reg <= '0;
		end else if (!ref_due) begin
			ref_cnt_reg <= ref_cnt_reg + 1'b1;
		end
	end

	// ----------------------------------------
	// Sequence controller
	// ----------------------------------------
	logic err_reg;
	logic err_set;

	// A bad word finished in the cycle of a Clear still raises the error: set beats clear
	assign err_set = done_reg && (((state_reg == ST_ENTER) && !in_ok)
		|| ((state_reg == ST_RO_ADDR) && !addr_ok(word_reg[11:0])));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg    <= ST_IDLE;
			err_reg      <= 1'b0;
			ro_addr_reg  <= '0;
			start_rx_reg <= 1'b0;
			start_tx_reg <= 1'b0;
			start_n_reg  <= 4'h0;
			abort_reg    <= 1'b0;
			store_reg    <= 1'b0;
		end else begin
			start_rx_reg <= 1'b0;
			start_tx_reg <= 1'b0;
			abort_reg    <= 1'b0;
			store_reg    <= 1'b0;
			if (ev_clear) begin
				state_reg <= err_set ? ST_ERROR : ST_CLEAR;
				err_reg   <= err_set;
				abort_reg <= 1'b1;
			end else begin
				case (state_reg)
					ST_CLEAR: begin
						if (ev_readout) begin
							state_reg    <= ST_RO_ADDR;
							start_rx_reg <= 1'b1;
							start_n_reg  <= ADDR_GROUPS;
						end else if (ev_enter) begin
							state_reg    <= ST_ENTER;
							start_rx_reg <= 1'b1;
							start_n_reg  <= WORD_GROUPS;
						end
					end
					ST_ENTER: begin
						if (done_reg && in_ok) begin
							store_reg <= 1'b1;
							state_reg <= ST_DONE;
						end else if (done_reg) begin
							err_reg   <= 1'b1;
							state_reg <= ST_ERROR;
						end
					end
					ST_RO_ADDR: begin
						if (done_reg && addr_ok(word_reg[11:0])) begin
							ro_addr_reg <= addr_of(word_reg[11:0]);
							state_reg   <= ST_RO_FETCH;
						end else if (done_reg) begin
							err_reg   <= 1'b1;
							state_reg <= ST_ERROR;
						end
					end
					ST_RO_FETCH: begin
						start_tx_reg <= 1'b1;
						start_n_reg  <= WORD_GROUPS;
						state_reg    <= ST_RO_SEND;
					end
					ST_RO_SEND: begin
						if (ev_hold) begin
							abort_reg <= 1'b1;
							state_reg <= ST_HOLD;
						end else if (done_reg) begin
							state_reg <= ST_RO_WAIT;
						end
					end
					ST_RO_WAIT: begin
						if (ev_hold) begin
							state_reg <= ST_HOLD;
						end else if (ref_due) begin
							state_reg <= ST_RO_FETCH;
						end
					end
					ST_HOLD: begin
						if (ev_readout) begin
							state_reg <= ST_RO_FETCH;
						end
					end
					// Idle, done and error wait for Clear only
					ST_IDLE, ST_DONE, ST_ERROR: begin
						state_reg <= state_reg;
					end
					default: begin
						state_reg <= ST_IDLE;
					end
				endcase
			end
		end
	end

	assign operator_error = err_reg;

endmodule

`default_nettype wire

// ### verif/kdwl_core_monitor.sv
// Assertion checker for the keypad display word link core
`default_nettype none

module kdwl_core_monitor
	import kdwl_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES  = SAMPLE_CYC,
	parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
) (
	input wire logic              clk,                    // Clock
	input wire logic              rst_n,                  // Reset
	input wire kdwl_keys_t        keys,                   // Keys
	input wire logic              link_clk,               // Link clock
	input wire logic              link_din,               // Data in
	input wire logic              link_dout,              // Data out
	input wire logic              group_receive_request,  // Receive req
	input wire logic              group_send_request,     // Send req
	input wire logic              operator_error,         // Error
	input wire logic [MEM_AW-1:0] mem_addr,               // Address
	input wire kdwl_word_t        mem_wdata,              // Write data
	input wire logic              mem_wr,                 // Write strobe
	input wire logic              mem_rd,                 // Read strobe
	input wire kdwl_word_t        mem_rdata               // Read data
);
	logic [9:0] gap_reg;
	logic [9:0] rx_age_reg;
	logic       clr_seen_reg;

	// Saturating ages; start saturated so the first request is legal
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_reg    <= 10'h3ff;
			rx_age_reg <= 10'h3ff;
		end else begin
			gap_reg    <= (group_receive_request || group_send_request) ? 10'h000 :
			              (gap_reg == 10'h3ff) ? gap_reg : gap_reg + 10'h001;
			rx_age_reg <= group_receive_request ? 10'h000 :
			              (rx_age_reg == 10'h3ff) ? rx_age_reg : rx_age_reg + 10'h001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			clr_seen_reg <= 1'b0;
		else if (keys.clear)
			clr_seen_reg <= 1'b1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_req;
		group_receive_request || group_send_request;
	endsequence
	// Sync plus sample tick puts the key a few cycles behind
	sequence s_clr_recent;
		$past(keys.clear, 2) || $past(keys.clear, 3) || $past(keys.clear, 4) || $past(keys.clear, 5);
	endsequence

	chk_req_gap: assert property (s_req |-> gap_reg >= 10'h31f)
		else $error("group requests closer than 800 cycles");
	chk_req_excl: assert property (!(group_receive_request && group_send_request))
		else $error("receive and send requested together");
	chk_err_clear: assert property ($fell(operator_error) |-> s_clr_recent)
		else $error("error dropped without a clear key");
	chk_err_quiet: assert property (operator_error && $past(operator_error) |->
		!(group_receive_request || group_send_request))
		else $error("request issued while error stands");
	chk_err_cause: assert property ($rose(operator_error) |-> rx_age_reg < 10'h3e8)
		else $error("error raised without a received group");
	chk_idle_quiet: assert property (!clr_seen_reg |-> !(group_receive_request || group_send_request))
		else $error("request before the first clear");
	chk_rdata_hold: assert property (!$past(mem_rd) |-> $stable(mem_rdata))
		else $error("read data changed without a read");
	chk_rd_back: assert property (mem_rd && $past(mem_wr) && mem_addr == $past(mem_addr) |=>
		mem_rdata == $past(mem_wdata, 2))
		else $error("read after write returned other data");
endmodule

bind kdwl_core kdwl_core_monitor #(
	.SAMPLE_CYCLES (SAMPLE_CYCLES),
	.REFRESH_CYCLES(REFRESH_CYCLES)
) u_mon (
	.clk(clk), .rst_n(rst_n), .keys(keys), .link_clk(link_clk), .link_din(link_din),
	.link_dout(link_dout), .group_receive_request(group_receive_request),
	.group_send_request(group_send_request), .operator_error(operator_error),
	.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd),
	.mem_rdata(mem_rdata)
);

`default_nettype wire

// ### verif/kdwl_keypad_model.sv
// Behavioural keypad and display unit answering group requests
`default_nettype none

module kdwl_keypad_model (
	input  wire logic        clk,       // System clock
	input  wire logic        rx_req,    // Group receive request
	input  wire logic        tx_req,    // Group send request
	input  wire logic        dout,      // Serial data from core
	input  wire logic        load,      // Load word to key in
	input  wire logic [35:0] word_in,   // Word to key in
	output logic             link_clk,  // Burst clock
	output logic             link_din,  // Serial data to core
	output logic      [35:0] word_out   // Last 36 bits shown
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [35:0] sr;

	// Phase unrelated to clk; clock rests low between bursts
	// Loading is only done while the core is idle, so no burst is missed
	initial begin
		link_clk = 1'b0;
		link_din = 1'b0;
		word_out = 36'h0;
		sr       = 36'h0;
		forever begin
			@(posedge load or posedge clk iff (rx_req || tx_req));
			if (!(rx_req || tx_req)) begin
				sr = word_in;
			end else begin
				#237;
				repeat (4) begin
					link_din = sr[35];
					sr = {sr[34:0], 1'b0};
					#200 link_clk = 1'b1;
					word_out = {word_out[34:0], dout};
					#400 link_clk = 1'b0;
					#200;
				end
				link_din = ~link_din;  // Released line must not keep its value
			end
		end
	end
endmodule

`default_nettype wire

// ### verif/keypad_display_word_link_tb_top.sv
// Self-checking bench for the keypad display word link core
`default_nettype none

module keypad_display_word_link_tb_top
	import kdwl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic              clk;
	logic              rst_n;
	kdwl_keys_t        keys;
	logic              link_clk;
	logic              link_din;
	logic              link_dout;
	logic              rq;
	logic              sq;
	logic              oerr;
	logic [MEM_AW-1:0] maddr;
	kdwl_word_t        wdata;
	kdwl_word_t        rdata;
	kdwl_word_t        w;
	kdwl_word_t        got;
	logic              mwr;
	logic              mrd;
	logic              load;
	logic [35:0]       kin;
	logic [35:0]       kout;
	logic [8:0]        a;
	logic [31:0]       lfsr;
	int                err_count, tests_run, cyc, nrx, ntx, b, t;

	kdwl_core #(.SAMPLE_CYCLES(20), .REFRESH_CYCLES(10000)) DUT (
		.clk(clk), .rst_n(rst_n), .keys(keys), .link_clk(link_clk), .link_din(link_din),
		.link_dout(link_dout), .group_receive_request(rq), .group_send_request(sq),
		.operator_error(oerr), .mem_addr(maddr), .mem_wdata(wdata), .mem_wr(mwr),
		.mem_rd(mrd), .mem_rdata(rdata));

	kdwl_keypad_model u_pad (
		.clk(clk), .rx_req(rq), .tx_req(sq), .dout(link_dout), .load(load),
		.word_in(kin), .link_clk(link_clk), .link_din(link_din), .word_out(kout));

	initial clk = 1'b0;
	always #50 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		nrx += rq;
		ntx += sq;
		if (cyc == 100000) begin
			err_count++;
			finish_test();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Outgoing word: octal digits or BCD, zero-forced bits
	function automatic logic [35:0] fmt(input logic [8:0] ad, input kdwl_word_t v);
		logic [19:0] d;
		logic [19:0] m;
		m = (v.mag > DEC_MAX) ? DEC_MAX : v.mag;
		for (int i = 0; i < 5; i++) begin
			d[i*4 +: 4] = ad[8] ? 4'(m % 10) : {1'b0, v.mag[i*3 +: 3]};
			m = m / 10;
		end
		return {1'b0, ad[8:6], 1'b0, ad[5:3], 1'b0, ad[2:0], 3'h0, v.neg, d};
	endfunction

	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic press(input kdwl_keys_t k);
		keys <= k;
		repeat (30) @(posedge clk);
		keys <= 4'h0;
		repeat (30) @(posedge clk);
	endtask

	task automatic wr(input logic [8:0] ad, input kdwl_word_t d);
		mwr   <= 1'b1;
		maddr <= ad;
		wdata <= d;
		@(posedge clk);
		mwr <= 1'b0;
	endtask

	task automatic rd(input logic [8:0] ad, output kdwl_word_t d);
		mrd   <= 1'b1;
		maddr <= ad;
		@(posedge clk);
		mrd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask

	task automatic wait_n(ref int c, input int n, input int lim);
		for (int i = 0; i < lim && c < n; i++) @(posedge clk);
	endtask

	// Clear first, then the given key; word is keyed in by the pad
	task automatic go(input logic [35:0] wd, input kdwl_keys_t k);
		kin  <= wd;
		load <= 1'b1;
		press(4'h8);
		load <= 1'b0;
		b = nrx;
		t = ntx;
		press(k);
	endtask

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{keys, mwr, mrd, maddr, wdata, load, kin} = '0;
		{err_count, tests_run, cyc, nrx, ntx} = '0;
		lfsr  = 32'hbbc5;
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check(oerr, 1'b0);
		press(4'h4);
		repeat (900) @(posedge clk);
		check(nrx, 0);
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			w = lfsr[20:0];
			wr(lfsr[28:20], w);
			rd(lfsr[28:20], got);
			check(got, w);
		end
		for (int k = 0; k < 2; k++) begin
			lfsr = lfsr_next(lfsr);
			a = {k[0], lfsr[7:0]};
			w.neg = lfsr[9];
			w.mag = k ? 20'(lfsr[31:12] % 100000) : {5'h0, lfsr[26:12]};
			go(fmt(a, w), 4'h4);
			wait_n(nrx, b + 9, 8000);
			repeat (100) @(posedge clk);
			check(nrx - b, 9);
			rd(a, got);
			check(got, w);
			press(4'h4);
			repeat (900) @(posedge clk);
			check(nrx - b, 9);
		end
		for (int k = 0; k < 2; k++) begin
			go(k ? 36'h800000000 : 36'hfffffffff, 4'h4);
			wait_n(nrx, b + 9, 8000);
			repeat (100) @(posedge clk);
			check(oerr, 1'b1);
			b = nrx;
			press(4'h2);
			repeat (900) @(posedge clk);
			check(nrx + ntx, b + t);
		end
		press(4'h8);
		check(oerr, 1'b0);
		lfsr = lfsr_next(lfsr);
		a = {1'b1, lfsr[7:0]};
		w = lfsr[20:0];
		wr(a, w);
		go(fmt(a, '0), 4'h2);
		wait_n(ntx, t + 9, 11000);
		check(nrx - b, 3);
		repeat (100) @(posedge clk);
		check(kout, fmt(a, w));
		wait_n(ntx, t + 18, 21000);
		check(ntx - t, 18);
		press(4'h1);
		t = ntx;
		repeat (11000) @(posedge clk);
		check(ntx, t);
		w = lfsr[30:10];
		wr(a, w);
		press(4'h2);
		wait_n(ntx, t + 9, 9000);
		repeat (100) @(posedge clk);
		check(nrx - b, 3);
		check(kout, fmt(a, w));
		lfsr = lfsr_next(lfsr);
		w = lfsr[20:0];
		wr(9'h000, w);
		go(36'h0, 4'h2);
		wait_n(nrx, b + 1, 1000);
		check(nrx - b, 1);
		wait_n(ntx, t + 9, 11000);
		repeat (100) @(posedge clk);
		check(nrx - b, 3);
		check(kout, fmt(9'h000, w));
		finish_test();
	end
endmodule

`default_nettype wire
